// >>> logic/rx_port_cfg.svh
// register offsets, field positions, reset values and decode constants
`ifndef RX_PORT_CFG_SVH
`define RX_PORT_CFG_SVH
`define ADDR_PCLK_SRC 8'h2E
`define ADDR_DUAL_RX 8'h34
`define ADDR_EQ_CTL 8'h35
`define ADDR_MODE_STAT 8'h37
`define ADDR_AUD_DIV 8'h3A
`define ADDR_EQ_STAT 8'h3B
`define ADDR_EQ_FLOOR 8'h45
`define RST_PCLK_SRC 8'h00
`define RST_DUAL_RX 8'h01
`define RST_EQ_CTL 8'h00
`define RST_AUD_DIV 8'h00
`define RST_EQ_FLOOR 4'h8
`define MASK_PCLK_SRC 8'h80
`define MASK_DUAL_RX 8'h7B
`define MASK_EQ_CTL 8'h70
`define MASK_AUD_DIV 8'hF7
`define MASK_EQ_FLOOR 8'h0F
`define BIT_EXT_PCLK 7
`define BIT_LOCK_MODE 6
`define BIT_RAW_BC 5
`define BIT_MODE_HI 4
`define BIT_MODE_LO 3
`define BIT_PORT1 1
`define BIT_PORT0 0
`define BIT_EQ_RESTART 6
`define BIT_FLOOR_OVR 5
`define BIT_FLOOR_APPLY 4
`define BIT_MDIV_OVR 7
`define BIT_MDIV_HI 6
`define BIT_MDIV_LO 4
`define BIT_MSEL_OVR 2
`define BIT_MSEL_HI 1
`define BIT_MSEL_LO 0
`define BIT_MODE_A_DONE 3
`define EQ_ZERO 6'h00
`define MODE_SETTLE 4'h3
`endif

// >>> logic/rx_port_pkg.sv
// types shared by the receiver port configuration bank
package rx_port_pkg;
  typedef enum logic [1:0] {
    in_auto, in_dual, in_single_primary, in_single_secondary
  } input_mode_e;

  typedef struct packed {
    logic ext_pclk_sel;
    logic rx_lock;
    logic raw_bc_out;
    input_mode_e input_mode;
    logic [5:0] mclk_div_ratio;
    logic mclk_div_override;
    logic [3:0] ref_div_ratio;
  } link_ctrl_s;

  typedef struct packed {
    logic restart;
    logic start_from_floor;
    logic [3:0] floor_port0;
    logic [3:0] floor_port1;
  } eq_ctrl_s;
endpackage : rx_port_pkg

// >>> logic/rx_port_cfg_regs.sv
// configuration and status register bank of the dual-input link receiver
`timescale 1ns/1ps
`include "rx_port_cfg.svh"

module rx_port_cfg_regs #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_linked,
  input wire logic i_video_disabled,
  input wire logic i_first_general_pin,
  input wire logic [2:0] i_mode_pin_a_level,
  input wire logic [2:0] i_mode_pin_b_level,
  input wire logic [1:0] i_sm_ref_div,
  input wire logic [5:0] i_eq_setting_port0,
  input wire logic [5:0] i_eq_setting_port1,
  output rx_port_pkg::link_ctrl_s o_link,
  output rx_port_pkg::eq_ctrl_s o_eq
);
  import rx_port_pkg::*;

  logic [7:0] pclk_src_r;
  logic [7:0] dual_rx_r;
  logic [7:0] eq_ctl_p0_r;
  logic [7:0] eq_ctl_p1_r;
  logic [7:0] aud_div_r;
  logic [3:0] floor_p0_r;
  logic [3:0] floor_p1_r;
  logic [7:0] mode_stat_r;
  logic [5:0] equalizer_setting_r;
  logic [3:0] settle_r;
  logic [5:0] mode_a_s1_r, mode_a_s2_r;
  logic [1:0] lk_s1_r, lk_s2_r;
  logic gp_s1_r, gp_s2_r;
  logic [11:0] eq_s1_r, eq_s2_r;
  logic [7:0] rdata_nxt;
  link_ctrl_s link_nxt;
  eq_ctrl_s eq_nxt;

  // maps the three-bit output divider code to a divide ratio
  function automatic logic [5:0] mdiv_ratio(input logic [2:0] code);
    case (code)
      3'h0: mdiv_ratio = 6'h20;
      3'h1: mdiv_ratio = 6'h10;
      3'h2: mdiv_ratio = 6'h08;
      3'h3: mdiv_ratio = 6'h04;
      3'h4, 3'h5: mdiv_ratio = 6'h02;
      default: mdiv_ratio = 6'h01;
    endcase
  endfunction : mdiv_ratio

  // maps the two-bit reference divider code to a divide ratio
  function automatic logic [3:0] msel_ratio(input logic [1:0] code);
    msel_ratio = 4'h1 << code;
  endfunction : msel_ratio

  // pin and foreign-logic inputs other than i_sm_ref_div pass two flip-flops
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_a_s1_r <= 6'h00;
      mode_a_s2_r <= 6'h00;
      lk_s1_r <= 2'h0;
      lk_s2_r <= 2'h0;
      gp_s1_r <= 1'b0;
      gp_s2_r <= 1'b0;
      eq_s1_r <= 12'h000;
      eq_s2_r <= 12'h000;
    end else begin
      mode_a_s1_r <= {i_mode_pin_b_level, i_mode_pin_a_level};
      mode_a_s2_r <= mode_a_s1_r;
      lk_s1_r <= {i_video_disabled, i_linked};
      lk_s2_r <= lk_s1_r;
      gp_s1_r <= i_first_general_pin;
      gp_s2_r <= gp_s1_r;
      eq_s1_r <= {i_eq_setting_port1, i_eq_setting_port0};
      eq_s2_r <= eq_s1_r;
    end
  end

  // shared registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pclk_src_r <= `RST_PCLK_SRC;
      dual_rx_r <= `RST_DUAL_RX;
      aud_div_r <= `RST_AUD_DIV;
    end else if (i_wr_en) begin
      if (i_addr == `ADDR_PCLK_SRC) begin
        pclk_src_r <= i_wdata & `MASK_PCLK_SRC;
      end else if (i_addr == `ADDR_DUAL_RX) begin
        dual_rx_r <= i_wdata & `MASK_DUAL_RX;
      end else if (i_addr == `ADDR_AUD_DIV) begin
        aud_div_r <= i_wdata & `MASK_AUD_DIV;
      end
    end
  end

  // per-port copies: written through whichever port selects are set
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      eq_ctl_p0_r <= `RST_EQ_CTL;
      eq_ctl_p1_r <= `RST_EQ_CTL;
      floor_p0_r <= `RST_EQ_FLOOR;
      floor_p1_r <= `RST_EQ_FLOOR;
    end else if (i_wr_en) begin
      if (i_addr == `ADDR_EQ_CTL) begin
        if (dual_rx_r[`BIT_PORT0]) begin
          eq_ctl_p0_r <= i_wdata & `MASK_EQ_CTL;
        end
        if (dual_rx_r[`BIT_PORT1]) begin
          eq_ctl_p1_r <= i_wdata & `MASK_EQ_CTL;
        end
      end else if (i_addr == `ADDR_EQ_FLOOR) begin
        if (dual_rx_r[`BIT_PORT0]) begin
          floor_p0_r <= i_wdata[3:0];
        end
        if (dual_rx_r[`BIT_PORT1]) begin
          floor_p1_r <= i_wdata[3:0];
        end
      end
    end
  end

  // mode pins are latched once after a settle period, then flagged done
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      settle_r <= 4'h0;
      mode_stat_r <= 8'h00;
    end else if (settle_r != SETTLE_CYCLES[3:0]) begin
      settle_r <= settle_r + 4'h1;
    end else if (!mode_stat_r[`BIT_MODE_A_DONE]) begin
      mode_stat_r <= {1'b1, mode_a_s2_r[5:3], 1'b1, mode_a_s2_r[2:0]};
    end
  end

  // equalizer status follows the port selected for reads
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      equalizer_setting_r <= `EQ_ZERO;
    end else if (dual_rx_r[`BIT_PORT1]) begin
      equalizer_setting_r <= eq_s2_r[11:6];
    end else begin
      equalizer_setting_r <= eq_s2_r[5:0];
    end
  end

  // read data: port-one copies win when that select is set
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_addr == `ADDR_PCLK_SRC) begin
      rdata_nxt = pclk_src_r;
    end else if (i_addr == `ADDR_DUAL_RX) begin
      rdata_nxt = dual_rx_r;
    end else if (i_addr == `ADDR_EQ_CTL) begin
      rdata_nxt = dual_rx_r[`BIT_PORT1] ? eq_ctl_p1_r : eq_ctl_p0_r;
    end else if (i_addr == `ADDR_MODE_STAT) begin
      rdata_nxt = mode_stat_r;
    end else if (i_addr == `ADDR_AUD_DIV) begin
      rdata_nxt = aud_div_r;
    end else if (i_addr == `ADDR_EQ_STAT) begin
      rdata_nxt = {2'h0, equalizer_setting_r};
    end else if (i_addr == `ADDR_EQ_FLOOR) begin
      rdata_nxt = {4'h0, dual_rx_r[`BIT_PORT1] ? floor_p1_r : floor_p0_r};
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      o_rdata <= rdata_nxt;
    end
  end

  // link-side and equalizer controls decoded from the registers and inputs
  always_comb begin
    link_nxt.ext_pclk_sel = pclk_src_r[`BIT_EXT_PCLK];
    if (dual_rx_r[`BIT_LOCK_MODE]) begin
      link_nxt.rx_lock = lk_s2_r[0];
    end else begin
      link_nxt.rx_lock = lk_s2_r[0] & ~lk_s2_r[1];
    end
    link_nxt.raw_bc_out = dual_rx_r[`BIT_RAW_BC] & gp_s2_r;
    link_nxt.input_mode = input_mode_e'(dual_rx_r[`BIT_MODE_HI:`BIT_MODE_LO]);
    link_nxt.mclk_div_override = aud_div_r[`BIT_MDIV_OVR];
    link_nxt.mclk_div_ratio = mdiv_ratio(aud_div_r[`BIT_MDIV_HI:`BIT_MDIV_LO]);
    if (aud_div_r[`BIT_MSEL_OVR]) begin
      link_nxt.ref_div_ratio = msel_ratio(aud_div_r[`BIT_MSEL_HI:`BIT_MSEL_LO]);
    end else begin
      link_nxt.ref_div_ratio = msel_ratio(i_sm_ref_div);
    end
    eq_nxt.restart = eq_ctl_p0_r[`BIT_EQ_RESTART] | eq_ctl_p1_r[`BIT_EQ_RESTART];
    eq_nxt.start_from_floor = eq_ctl_p0_r[`BIT_FLOOR_OVR]
                              & eq_ctl_p0_r[`BIT_FLOOR_APPLY];
    eq_nxt.floor_port0 = floor_p0_r;
    eq_nxt.floor_port1 = floor_p1_r;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_link <= '0;
      o_eq <= '0;
    end else begin
      o_link <= link_nxt;
      o_eq <= eq_nxt;
    end
  end

  property p_lock_video;
    @(posedge i_clock) disable iff (!i_reset_n)
      (!dual_rx_r[`BIT_LOCK_MODE] && lk_s2_r[1]) |=> !o_link.rx_lock;
  endproperty
  a_lock_video: assert property (p_lock_video) else $error("lock with video off");

  property p_lock_link;
    @(posedge i_clock) disable iff (!i_reset_n)
      (dual_rx_r[`BIT_LOCK_MODE] && lk_s2_r[0]) |=> o_link.rx_lock;
  endproperty
  a_lock_link: assert property (p_lock_link) else $error("no lock while linked");

  property p_port1_write;
    @(posedge i_clock) disable iff (!i_reset_n)
      (i_wr_en && i_addr == `ADDR_EQ_FLOOR && dual_rx_r[`BIT_PORT1])
      |=> floor_p1_r == $past(i_wdata[3:0]);
  endproperty
  a_port1_write: assert property (p_port1_write) else $error("port one copy missed");

  property p_port0_keep;
    @(posedge i_clock) disable iff (!i_reset_n)
      (i_wr_en && i_addr == `ADDR_EQ_FLOOR && !dual_rx_r[`BIT_PORT0]) |=> $stable(floor_p0_r);
  endproperty
  a_port0_keep: assert property (p_port0_keep) else $error("port zero written");

  property p_read_port1;
    @(posedge i_clock) disable iff (!i_reset_n)
      (i_rd_en && i_addr == `ADDR_EQ_CTL && dual_rx_r[`BIT_PORT1])
      |=> o_rdata == $past(eq_ctl_p1_r);
  endproperty
  a_read_port1: assert property (p_read_port1) else $error("read not port one");

  property p_floor_gate;
    @(posedge i_clock) disable iff (!i_reset_n)
      !eq_ctl_p0_r[`BIT_FLOOR_OVR] |=> !o_eq.start_from_floor;
  endproperty
  a_floor_gate: assert property (p_floor_gate) else $error("floor not gated");

  property p_mode_done;
    @(posedge i_clock) disable iff (!i_reset_n)
      $rose(mode_stat_r[7]) |-> mode_stat_r[6:4] == $past(mode_a_s2_r[5:3]);
  endproperty
  a_mode_done: assert property (p_mode_done) else $error("decode not latched");

  property p_mode_a;
    @(posedge i_clock) disable iff (!i_reset_n)
      mode_stat_r[3] |=> $stable(mode_stat_r[2:0]) && mode_stat_r[3];
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("decode a not held");

  property p_ref_div;
    @(posedge i_clock) disable iff (!i_reset_n)
      !aud_div_r[`BIT_MSEL_OVR] |=> o_link.ref_div_ratio == (4'h1 << $past(i_sm_ref_div));
  endproperty
  a_ref_div: assert property (p_ref_div) else $error("ref divider not from sm");

  property p_mdiv32;
    @(posedge i_clock) disable iff (!i_reset_n)
      aud_div_r[`BIT_MDIV_HI:`BIT_MDIV_LO] == 3'h0 |=> o_link.mclk_div_ratio == 6'h20;
  endproperty
  a_mdiv32: assert property (p_mdiv32) else $error("divide by 32 wrong");

  property p_ext_pclk;
    @(posedge i_clock) disable iff (!i_reset_n)
      pclk_src_r[`BIT_EXT_PCLK] |=> o_link.ext_pclk_sel;
  endproperty
  a_ext_pclk: assert property (p_ext_pclk) else $error("clock source wrong");

  property p_raw_bc;
    @(posedge i_clock) disable iff (!i_reset_n)
      dual_rx_r[`BIT_RAW_BC] |=> o_link.raw_bc_out == $past(gp_s2_r);
  endproperty
  a_raw_bc: assert property (p_raw_bc) else $error("raw channel wrong");

  property p_forced_dual;
    @(posedge i_clock) disable iff (!i_reset_n)
      dual_rx_r[`BIT_MODE_HI:`BIT_MODE_LO] == 2'h1 |=> o_link.input_mode == in_dual;
  endproperty
  a_forced_dual: assert property (p_forced_dual) else $error("dual not forced");

  property p_restart_held;
    @(posedge i_clock) disable iff (!i_reset_n)
      (eq_ctl_p0_r[`BIT_EQ_RESTART] && !i_wr_en)
      |=> eq_ctl_p0_r[`BIT_EQ_RESTART] && o_eq.restart;
  endproperty
  a_restart_held: assert property (p_restart_held) else $error("restart not held");

  property p_floor_apply;
    @(posedge i_clock) disable iff (!i_reset_n)
      (eq_ctl_p0_r[`BIT_FLOOR_OVR] && eq_ctl_p0_r[`BIT_FLOOR_APPLY])
      |=> o_eq.start_from_floor && o_eq.floor_port0 == $past(floor_p0_r);
  endproperty
  a_floor_apply: assert property (p_floor_apply) else $error("floor not applied");

  property p_mdiv_ovr;
    @(posedge i_clock) disable iff (!i_reset_n)
      aud_div_r[`BIT_MDIV_OVR] |=> o_link.mclk_div_override;
  endproperty
  a_mdiv_ovr: assert property (p_mdiv_ovr) else $error("override not applied");

  property p_ref_div8;
    @(posedge i_clock) disable iff (!i_reset_n)
      (aud_div_r[`BIT_MSEL_OVR] && aud_div_r[`BIT_MSEL_HI:`BIT_MSEL_LO] == 2'h3)
      |=> o_link.ref_div_ratio == 4'h8;
  endproperty
  a_ref_div8: assert property (p_ref_div8) else $error("divide by 8 wrong");

  property p_port0_write;
    @(posedge i_clock) disable iff (!i_reset_n)
      (i_wr_en && i_addr == `ADDR_EQ_FLOOR && dual_rx_r[`BIT_PORT0])
      |=> floor_p0_r == $past(i_wdata[3:0]);
  endproperty
  a_port0_write: assert property (p_port0_write) else $error("port zero missed");
endmodule : rx_port_cfg_regs

// >>> dv/host_model.sv
// register host model: one-cycle write and read strobes
`timescale 1ns/1ps
module host_model (
  input wire logic i_clock,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    // released lines show a changed pattern
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
  endtask : rd
endmodule : host_model

// >>> dv/tb_rx_port_cfg_regs.sv
// self-checking bench for the receiver port configuration bank
`timescale 1ns/1ps
module tb_rx_port_cfg_regs;
  import rx_port_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic wr, rd, pend = 1'b0;
  logic linked = 1'b0, vdis = 1'b0, gp = 1'b0;
  logic [7:0] addr, wdata, o_rdata;
  logic [2:0] pa = 3'h0, pb = 3'h0;
  logic [1:0] smr = 2'h0;
  logic [5:0] eq0 = 6'h00, eq1 = 6'h00;
  logic [3:0] f;
  link_ctrl_s lk;
  eq_ctrl_s eq;
  logic [7:0] expq[$];
  logic [5:0] mtab [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h01};
  int err_count = 0, checked = 0, cyc = 0;
  logic [31:0] seed = 32'h00001ECB;

  rx_port_cfg_regs #(.SETTLE_CYCLES(4)) i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(o_rdata),
    .i_linked(linked), .i_video_disabled(vdis), .i_first_general_pin(gp),
    .i_mode_pin_a_level(pa), .i_mode_pin_b_level(pb), .i_sm_ref_div(smr),
    .i_eq_setting_port0(eq0), .i_eq_setting_port1(eq1), .o_link(lk), .o_eq(eq));
  host_model i_host (.i_clock(i_clock), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr),
    .o_wdata(wdata));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic wrap_up();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_host.rd(a);
  endtask : rdx

  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
  endtask : wait_n

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  // read data lands one edge after the strobe is taken
  always @(negedge i_clock) begin
    if (pend) chk(o_rdata, expq.size() > 0 ? expq.pop_front() : 8'hXX);
    pend = rd;
  end

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    seed = xs(seed);
    f = seed[31:28];
    pa <= seed[2:0];
    pb <= seed[6:4];
    eq0 <= seed[13:8];
    eq1 <= ~seed[13:8];
    smr <= seed[25:24];
    wait_n(8);
    i_reset_n <= 1'b1;
    wait_n(10);
    rdx(8'h2E, 8'h00);
    rdx(8'h34, 8'h01);
    rdx(8'h35, 8'h00);
    rdx(8'h3A, 8'h00);
    rdx(8'h45, 8'h08);
    rdx(8'h3B, {2'b00, eq0});
    rdx(8'h37, {1'b1, pb, 1'b1, pa});
    rdx(8'h10, 8'h00);
    i_host.wr(8'h37, 8'h00);
    i_host.wr(8'h3B, 8'hFF);
    rdx(8'h37, {1'b1, pb, 1'b1, pa});
    rdx(8'h3B, {2'b00, eq0});
    i_host.wr(8'h2E, 8'hFF);
    rdx(8'h2E, 8'h80);
    chk(8'(lk.ext_pclk_sel), 8'h01);
    for (int c = 0; c < 16; c++) begin
      i_host.wr(8'h3A, {c[3], c[2:0], 1'b1, c[3], c[1:0]});
      wait_n(3);
      chk(8'(lk.mclk_div_override), 8'(c[3]));
      if (c[3]) chk(8'(lk.mclk_div_ratio), 8'(mtab[c[2:0]]));
      chk(8'(lk.ref_div_ratio), 8'(4'h1 << (c[3] ? c[1:0] : smr)));
    end
    rdx(8'h3A, 8'hF7);
    linked <= 1'b1;
    vdis <= 1'b1;
    gp <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      i_host.wr(8'h34, {1'b1, c[2], c[2], c[1:0], 3'b111});
      wait_n(3);
      chk(8'(lk.rx_lock), 8'(c[2]));
      chk(8'(lk.raw_bc_out), 8'(c[2]));
      chk(8'(lk.input_mode), 8'(c[1:0]));
    end
    rdx(8'h34, 8'h7B);
    gp <= 1'b0;
    wait_n(5);
    chk(8'(lk.raw_bc_out), 8'h00);
    i_host.wr(8'h34, 8'h01);
    vdis <= 1'b0;
    wait_n(5);
    chk(8'(lk.rx_lock), 8'h01);
    linked <= 1'b0;
    wait_n(5);
    chk(8'(lk.rx_lock), 8'h00);
    i_host.wr(8'h34, 8'h03);
    i_host.wr(8'h45, {4'hF, f});
    rdx(8'h45, {4'h0, f});
    rdx(8'h3B, {2'b00, eq1});
    chk(8'(eq.floor_port0), 8'(f));
    chk(8'(eq.floor_port1), 8'(f));
    i_host.wr(8'h34, 8'h02);
    i_host.wr(8'h45, {4'h0, ~f});
    wait_n(3);
    chk(8'(eq.floor_port1), {4'h0, ~f});
    chk(8'(eq.floor_port0), 8'(f));
    rdx(8'h45, {4'h0, ~f});
    i_host.wr(8'h34, 8'h00);
    i_host.wr(8'h45, 8'h00);
    i_host.wr(8'h34, 8'h01);
    rdx(8'h45, {4'h0, f});
    rdx(8'h3B, {2'b00, eq0});
    i_host.wr(8'h35, 8'h10);
    wait_n(3);
    chk(8'(eq.start_from_floor), 8'h00);
    i_host.wr(8'h35, 8'hBF);
    rdx(8'h35, 8'h30);
    chk(8'(eq.start_from_floor), 8'h01);
    i_host.wr(8'h34, 8'h03);
    rdx(8'h35, 8'h00);
    // restart is held while the bit is high, not cleared by the device
    i_host.wr(8'h35, 8'h40);
    wait_n(5);
    chk(8'(eq.restart), 8'h01);
    rdx(8'h35, 8'h40);
    i_host.wr(8'h35, 8'h00);
    wait_n(3);
    chk(8'(eq.restart), 8'h00);
    wait_n(3);
    wrap_up();
  end
endmodule : tb_rx_port_cfg_regs
